//--- hdl/accd_core.sv
// Accessory detection control core: ID and USB discovery machines, switch
// and charger FET control, event flags, interrupt output, register file.
// Assumes a byte register port from a same-clock serial slave engine and
// analog comparator outputs that are asynchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module accd_core
  import accd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [4:0] connector_id_pin_code,
  input  wire logic       connector_id_pin_open,
  input  wire logic       vbus_cmp_pin,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            irq_n_out,
  output logic            host_port1_dplus,
  output logic            host_port1_dminus,
  output logic            audio_sw_close,
  output logic            mic_sw_close,
  output logic            vbus_fet_close,
  output logic            id_adc_enable,
  output logic            mic_overvoltage_guard_enable,
  output logic            dplus_bias_enable
);

  // Two-stage synchronisers for the analog comparator outputs.
  logic [4:0] code_s1_r, code_s2_r;   // ID code stages.
  logic       open_s1_r, open_s2_r;   // Open ID stages.
  logic       vbus_s1_r, vbus_s2_r;   // VBUS comparator stages.

  // Software-visible registers.
  logic [7:0] ctrl_r;                 // chip_control.
  logic [7:0] flags_r;                // event_flags.
  logic [7:0] evmask_r;               // Per-source event masks.
  logic [7:0] timing_r;               // Detection period select.
  logic [7:0] mansw_r;                // manual_switch_state_reg.
  logic [7:0] manchg_r;               // Manual charger control.
  logic [7:0] rdata_r;                // Read data.

  // Internal state.
  logic       srst_r;                 // Soft reset pulse.
  logic       att_r;                  // Attached, delayed.
  logic       vbus_d_r;               // VBUS valid, delayed.
  logic       irq_n_r;                // Interrupt line.
  logic [15:0] disc_cnt_r;            // Discovery step timer.
  accd_disc_t disc_r, disc_nxt;       // USB discovery state.
  accd_id_t   id_r, id_nxt;           // ID machine state.
  logic       host_r, aud_r, mic_r, fet_r;  // Switch drives.

  accd_id_if idp ();

  // Synchronises all pin inputs through two flip-flops.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      code_s1_r <= CODE_FLOAT;
      code_s2_r <= CODE_FLOAT;
      open_s1_r <= 1'b1;
      open_s2_r <= 1'b1;
      vbus_s1_r <= 1'b0;
      vbus_s2_r <= 1'b0;
    end else begin
      code_s1_r <= connector_id_pin_code;
      code_s2_r <= code_s1_r;
      open_s1_r <= connector_id_pin_open;
      open_s2_r <= open_s1_r;
      vbus_s1_r <= vbus_cmp_pin;
      vbus_s2_r <= vbus_s1_r;
    end
  end

  // Decoded control fields.
  wire int_mask  = ctrl_r[CTRL_INTMASK_BIT];
  wire man_en    = ctrl_r[CTRL_MANEN_BIT];
  wire id_measure_disable    = ctrl_r[CTRL_IDDIS_BIT];

  // VBUS is valid only when the comparator reports above threshold.
  wire vbus_ok   = vbus_s2_r;
  wire id_open   = open_s2_r;
  wire attached  = !id_open || vbus_ok;
  wire detach    = id_open && !vbus_ok;

  // Register port decode.
  wire wr_ctrl   = reg_wr && (reg_addr == OFS_CTRL);
  wire wr_evmask = reg_wr && (reg_addr == OFS_EVMASK);
  wire wr_timing = reg_wr && (reg_addr == OFS_TIMING);
  wire wr_mansw  = reg_wr && (reg_addr == OFS_MANSW);
  wire wr_manchg = reg_wr && (reg_addr == OFS_MANCHG);
  wire rd_flags  = reg_rd && (reg_addr == OFS_FLAGS);

  // Soft reset starts on a write with the reset bit low.
  wire srst_req  = wr_ctrl && !reg_wdata[CTRL_SRSTN_BIT];

  // Resistance measurement stays powered only while ID is not open and,
  // once the first attach has settled, while not disabled by software.
  wire meas_on   = !id_open && !(id_measure_disable && (id_r == ID_MON));

  // The open detector always runs, so removal is seen as code zero
  // whatever the disable bit holds.
  assign idp.sample_code = id_open ? CODE_FLOAT :
                           meas_on ? code_s2_r : idp.acc_code;
  assign idp.need_two    = (id_r == ID_MON);

  // Period is the programmed count plus one, in detection units.
  wire [15:0] period = 16'((timing_r[3:0] + 16'h0001) * DET_UNIT_CYC);

  accd_id_sampler u_sampler (
    .clock      (clock),
    .reset      (reset),
    .sreset     (srst_r),
    .period_cyc (period),
    .idp        (idp)
  );

  wire [4:0] code    = idp.acc_code;
  wire       id_res  = (code != CODE_FLOAT);
  wire       aca_a   = (code == CODE_ACA_A);
  wire       auto_cd = (code == CODE_ACA_C) || (code == CODE_ACA_B) ||
                       aca_a || (code == CODE_FLOAT);

  // ID machine: open, initial attach, then monitoring.
  always_comb begin
    id_nxt = id_r;
    case (id_r)
      ID_OPEN: begin
        if (attached) begin
          id_nxt = ID_INIT;
        end
      end
      ID_INIT: begin
        if (!attached) begin
          id_nxt = ID_OPEN;
        end else if (idp.agreed) begin
          id_nxt = ID_MON;
        end
      end
      ID_MON: begin
        if (!attached) begin
          id_nxt = ID_OPEN;
        end
      end
      default: id_nxt = ID_OPEN;
    endcase
  end

  // Discovery step ends when the timer runs out.
  wire step_end = (disc_cnt_r == 16'(DISC_STEP_CYC - 1));

  // USB discovery machine: one pass per VBUS attach.
  always_comb begin
    disc_nxt = disc_r;
    case (disc_r)
      DISC_IDLE: begin
        if (vbus_ok) begin
          disc_nxt = DISC_RUN;
        end
      end
      DISC_RUN: begin
        if (!vbus_ok) begin
          disc_nxt = DISC_IDLE;
        end else if (step_end) begin
          // A measured ID halts the flow unless it is a type A adapter.
          disc_nxt = (id_res && !aca_a) ? DISC_HALT
                                        : DISC_DONE;
        end
      end
      DISC_DONE, DISC_HALT: begin
        if (!vbus_ok) begin
          disc_nxt = DISC_IDLE;
        end
      end
      default: disc_nxt = DISC_IDLE;
    endcase
  end

  // Advances the state machines and the discovery timer.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      id_r       <= ID_OPEN;
      disc_r     <= DISC_IDLE;
      disc_cnt_r <= 16'h0000;
    end else if (srst_r) begin
      id_r       <= ID_OPEN;
      disc_r     <= DISC_IDLE;
      disc_cnt_r <= 16'h0000;
    end else begin
      id_r       <= id_nxt;
      disc_r     <= disc_nxt;
      disc_cnt_r <= (disc_r == DISC_RUN && !step_end) ?
                    disc_cnt_r + 16'h0001 : 16'h0000;
    end
  end

  // Switch targets. Manual mode applies the stored states on attach, the FET state only while VBUS is valid;
  // automatic mode closes the host path for plain USB ports and the
  // adapter codes once discovery is complete.
  wire usb_auto = vbus_ok && (disc_r == DISC_DONE) && auto_cd;
  wire fet_man  = (mansw_r[1:0] == MANSW_FET_CLOSED);
  wire host_nxt = detach ? 1'b0 :
                  man_en ? mansw_r[MANSW_HOST_BIT] : usb_auto;
  wire aud_nxt  = !detach && man_en && mansw_r[MANSW_AUD_BIT];
  wire mic_nxt  = !detach && man_en && mansw_r[MANSW_MIC_BIT];
  wire fet_nxt  = vbus_ok && (!man_en || fet_man);

  // Event sources, each with its own mask bit.
  wire [7:0] ev;
  assign ev[FLAG_ATTACH_BIT] = attached && !att_r;
  assign ev[FLAG_DETACH_BIT] = !attached && att_r;
  assign ev[FLAG_RCHG_BIT]   = idp.changed;
  assign ev[FLAG_VBCHG_BIT]  = vbus_ok != vbus_d_r;
  assign ev[7:4]             = 4'h0;

  // Reading clears the flags, but an event in the same cycle survives.
  wire [7:0] flags_nxt = (rd_flags ? 8'h00 : flags_r) | ev;
  wire       pending   = |(flags_r & ~evmask_r);

  // Drives the switches and tracks attach and VBUS history.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      host_r   <= 1'b0;
      aud_r    <= 1'b0;
      mic_r    <= 1'b0;
      fet_r    <= 1'b0;
      att_r    <= 1'b0;
      vbus_d_r <= 1'b0;
    end else begin
      host_r   <= host_nxt;
      aud_r    <= aud_nxt;
      mic_r    <= mic_nxt;
      fet_r    <= fet_nxt;
      att_r    <= attached;
      vbus_d_r <= vbus_ok;
    end
  end

  // Registers that only a hardware reset restores.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_r   <= CTRL_RST;
      mansw_r  <= MANSW_RST;
      manchg_r <= MANCHG_RST;
      srst_r   <= 1'b0;
    end else begin
      srst_r <= srst_req;
      if (wr_ctrl) begin
        // The reset bit always reads back high.
        ctrl_r <= reg_wdata | CTRL_RST & 8'h40;
      end
      if (wr_mansw) begin
        mansw_r <= reg_wdata;
      end
      if (wr_manchg) begin
        manchg_r <= reg_wdata;
      end
    end
  end

  // Registers that a soft reset also restores.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags_r  <= FLAGS_RST;
      evmask_r <= EVMASK_RST;
      timing_r <= TIMING_RST;
    end else if (srst_r) begin
      flags_r  <= FLAGS_RST;
      evmask_r <= EVMASK_RST;
      timing_r <= TIMING_RST;
    end else begin
      flags_r <= flags_nxt;
      if (wr_evmask) begin
        evmask_r <= reg_wdata;
      end
      if (wr_timing) begin
        timing_r <= reg_wdata;
      end
    end
  end

  // Interrupt line: low while an unmasked flag is pending.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= !(!int_mask && pending);
    end
  end

  // Status word built from live state.
  wire [7:0] status;
  assign status[STAT_VBUS_BIT]  = vbus_ok;
  assign status[STAT_IDOPN_BIT] = id_res;
  assign status[STAT_ATT_BIT]   = attached;
  assign status[STAT_DISC_BIT]  = (disc_r == DISC_DONE);
  assign status[7:4]            = 4'h0;

  // Read mux; unmapped offsets read as zero.
  wire [7:0] rd_mux =
    (reg_addr == OFS_CTRL)   ? ctrl_r :
    (reg_addr == OFS_FLAGS)  ? flags_r :
    (reg_addr == OFS_TIMING) ? timing_r :
    (reg_addr == OFS_EVMASK) ? evmask_r :
    (reg_addr == OFS_RCODE)  ? {3'h0, code} :
    (reg_addr == OFS_STATUS) ? status :
    (reg_addr == OFS_MANSW)  ? mansw_r :
    (reg_addr == OFS_MANCHG) ? manchg_r : 8'h00;

  // Captures read data on a read strobe.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end
  end

  // Outputs; the interrupt line is push-pull and always driven.
  assign reg_rdata                    = rdata_r;
  assign irq_n_out                    = irq_n_r;
  assign host_port1_dplus             = host_r;
  assign host_port1_dminus            = host_r;
  assign audio_sw_close               = aud_r;
  assign mic_sw_close                 = mic_r;
  assign vbus_fet_close               = fet_r;
  assign id_adc_enable                = meas_on;
  assign mic_overvoltage_guard_enable = ctrl_r[CTRL_MICOVP_BIT];
  assign dplus_bias_enable            = manchg_r[MANCHG_DP_BIT] && vbus_ok;

  // Masked interrupt line stays high.
  irq_masked_a: assert property (@(posedge clock) disable iff (reset)
    int_mask |=> irq_n_out)
    else $error("interrupt line low while globally masked");

  // An unmasked pending flag pulls the line low next cycle.
  irq_fire_a: assert property (@(posedge clock) disable iff (reset)
    (!int_mask && pending) |=> !irq_n_out)
    else $error("pending event did not pull interrupt low");

  // Detach opens everything within two cycles.
  detach_open_a: assert property (@(posedge clock) disable iff (reset)
    detach [*2] |=> !(host_r || aud_r || mic_r || fet_r))
    else $error("switch left closed after detach");

  // Soft reset leaves the control register untouched.
  srst_keep_a: assert property (@(posedge clock) disable iff (reset)
    srst_r |=> (ctrl_r == $past(ctrl_r)) && (flags_r == FLAGS_RST))
    else $error("soft reset disturbed control or kept flags");

  // A read with no new event empties the flags.
  read_clear_a: assert property (@(posedge clock) disable iff (reset)
    (rd_flags && ev == 8'h00 && !srst_r) |=> (flags_r == 8'h00))
    else $error("flags not cleared by read");

  // Discovery never restarts without passing through idle.
  disc_once_a: assert property (@(posedge clock) disable iff (reset)
    (disc_r == DISC_DONE) |=> (disc_r != DISC_RUN))
    else $error("discovery ran twice on one attach");

  // A VBUS edge sets its flag unless a soft reset is under way.
  vbus_flag_a: assert property (@(posedge clock) disable iff (reset)
    ($changed(vbus_ok) && !srst_r) |=> flags_r[FLAG_VBCHG_BIT])
    else $error("VBUS change not flagged");

  // FET follows VBUS in automatic mode.
  fet_auto_a: assert property (@(posedge clock) disable iff (reset)
    (vbus_ok && !man_en) |=> fet_r)
    else $error("FET open with valid VBUS in automatic mode");

endmodule
`default_nettype wire

//--- hdl/accd_pkg.sv
// Package of the accessory detection control core: register offsets,
// field positions, reset values, resistor codes, timing counts and states.
// Assumes a single 100 MHz core clock shared by every module of the core.
package accd_pkg;

  // Core clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;

  // Register offsets on the internal register port.
  localparam logic [7:0] OFS_CTRL   = 8'h02;
  localparam logic [7:0] OFS_FLAGS  = 8'h03;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_EVMASK = 8'h05;
  localparam logic [7:0] OFS_RCODE  = 8'h06;
  localparam logic [7:0] OFS_STATUS = 8'h07;
  localparam logic [7:0] OFS_MANSW  = 8'h08;
  localparam logic [7:0] OFS_MANCHG = 8'h14;

  // Field positions of chip_control.
  localparam int CTRL_INTMASK_BIT = 0;
  localparam int CTRL_MANEN_BIT   = 2;
  localparam int CTRL_IDDIS_BIT   = 3;
  localparam int CTRL_MICOVP_BIT  = 5;
  localparam int CTRL_SRSTN_BIT   = 6;

  // Field positions of event_flags and of the event mask register.
  localparam int FLAG_ATTACH_BIT = 0;
  localparam int FLAG_DETACH_BIT = 1;
  localparam int FLAG_RCHG_BIT   = 2;
  localparam int FLAG_VBCHG_BIT  = 3;

  // Field positions of the status and manual registers.
  localparam int STAT_VBUS_BIT  = 0;
  localparam int STAT_IDOPN_BIT = 1;
  localparam int STAT_ATT_BIT   = 2;
  localparam int STAT_DISC_BIT  = 3;
  localparam int MANSW_HOST_BIT = 2;
  localparam int MANSW_AUD_BIT  = 3;
  localparam int MANSW_MIC_BIT  = 4;
  localparam int MANCHG_DP_BIT  = 2;
  localparam logic [1:0] MANSW_FET_CLOSED = 2'h3;

  // Reset values.
  localparam logic [7:0] CTRL_RST   = 8'h45;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] EVMASK_RST = 8'h00;
  localparam logic [7:0] TIMING_RST = 8'h00;
  localparam logic [7:0] MANSW_RST  = 8'h07;
  localparam logic [7:0] MANCHG_RST = 8'h00;

  // Resistor codes with a special meaning.
  localparam logic [4:0] CODE_FLOAT    = 5'h00;
  localparam logic [4:0] CODE_OTG      = 5'h16;
  localparam logic [4:0] CODE_SEND_END = 5'h0f;
  localparam logic [4:0] CODE_ACA_C    = 5'h11;
  localparam logic [4:0] CODE_ACA_B    = 5'h0d;
  localparam logic [4:0] CODE_ACA_A    = 5'h0a;

  // Agreeing samples needed on first attach and while monitoring.
  localparam logic [1:0] AGREE_INITIAL = 2'h3;
  localparam logic [1:0] AGREE_MONITOR = 2'h2;

  // Detection period unit and one discovery step, in time and cycles.
  localparam int DET_UNIT_NS   = 20000;
  localparam int DET_UNIT_CYC  = DET_UNIT_NS / CLK_PERIOD_NS;
  localparam int DISC_STEP_NS  = 10000;
  localparam int DISC_STEP_CYC = DISC_STEP_NS / CLK_PERIOD_NS;

  // USB discovery machine states.
  typedef enum logic [3:0] {
    DISC_IDLE = 4'h1,
    DISC_RUN  = 4'h2,
    DISC_DONE = 4'h4,
    DISC_HALT = 4'h8
  } accd_disc_t;

  // ID machine states.
  typedef enum logic [2:0] {
    ID_OPEN = 3'h1,
    ID_INIT = 3'h2,
    ID_MON  = 3'h4
  } accd_id_t;

endpackage

//--- hdl/accd_id_if.sv
// Interface between the control core and its ID resistance sampler.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface accd_id_if;
  logic [4:0] sample_code;  // Code presented for sampling.
  logic       need_two;     // High once initial attach has settled.
  logic [4:0] acc_code;     // Accepted code.
  logic       changed;      // Pulse when the accepted code changes.
  logic       agreed;       // Pulse when enough samples agree.

  modport sampler (input sample_code, input need_two,
                   output acc_code, output changed, output agreed);
  modport core    (output sample_code, output need_two,
                   input acc_code, input changed, input agreed);
endinterface
`default_nettype wire

//--- hdl/accd_id_sampler.sv
// ID resistance sampler: samples a code once per detection period and
// accepts it after three, later two, consecutive agreeing samples.
// Assumes synchronised codes and a period given in core clock cycles.
`timescale 1ns/1ps
`default_nettype none
module accd_id_sampler
  import accd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        sreset,
  input  wire logic [15:0] period_cyc,
  accd_id_if.sampler       idp
);

  logic [15:0] cnt_r;     // Period counter.
  logic [4:0]  last_r;    // Previous sample.
  logic [1:0]  agree_r;   // Run length of agreeing samples.
  logic [4:0]  acc_r;     // Accepted code.
  logic        chg_r;     // Change pulse.
  logic        agr_r;     // Agreement pulse.

  // Sampling tick, run length and acceptance test.
  wire       tick      = (cnt_r == period_cyc - 16'h0001);
  wire       same      = (idp.sample_code == last_r);
  wire [1:0] agree_nxt = !same ? 2'h1 :
                         (agree_r == 2'h3) ? 2'h3 : agree_r + 2'h1;
  wire [1:0] need      = idp.need_two ? AGREE_MONITOR : AGREE_INITIAL;
  wire       enough    = tick && (agree_nxt >= need);

  // Counts periods and accepts a code once the run is long enough.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_r   <= 16'h0000;
      last_r  <= CODE_FLOAT;
      agree_r <= 2'h0;
      acc_r   <= CODE_FLOAT;
      chg_r   <= 1'b0;
      agr_r   <= 1'b0;
    end else if (sreset) begin
      cnt_r   <= 16'h0000;
      last_r  <= CODE_FLOAT;
      agree_r <= 2'h0;
      acc_r   <= CODE_FLOAT;
      chg_r   <= 1'b0;
      agr_r   <= 1'b0;
    end else begin
      cnt_r <= tick ? 16'h0000 : cnt_r + 16'h0001;
      chg_r <= enough && (idp.sample_code != acc_r);
      agr_r <= enough;
      if (tick) begin
        last_r  <= idp.sample_code;
        agree_r <= agree_nxt;
      end
      if (enough) begin
        acc_r <= idp.sample_code;
      end
    end
  end

  assign idp.acc_code = acc_r;
  assign idp.changed  = chg_r;
  assign idp.agreed   = agr_r;

  // A change pulse always comes with a new accepted code.
  chg_code_a: assert property (@(posedge clock) disable iff (reset)
    chg_r |-> (acc_r != $past(acc_r)))
    else $error("change pulse without a new code");

  // Initial acceptance needs three agreeing samples.
  init_three_a: assert property (@(posedge clock) disable iff (reset)
    (enough && !idp.need_two) |-> (agree_nxt == 2'h3))
    else $error("code accepted with too few samples");

endmodule
`default_nettype wire

//--- test/accd_accessory_model.sv
// Accessory model: drives the connector ID code, the Id_open_flag level and
// the VBUS comparator. Assumes the bench calls its tasks after an edge.
`timescale 1ns/1ps
`default_nettype none
module accd_accessory_model (
  output var logic [4:0] id_code,
  output var logic       id_open,
  output var logic       vbus_ok
);
  // Nothing attached at start: ID floats and VBUS is absent.
  initial begin
    id_code = 5'h00;
    id_open = 1'b1;
    vbus_ok = 1'b0;
  end
  // Comparator output is high only for a supply above the threshold.
  task automatic set_vbus(input logic lvl);
    vbus_ok = lvl;
  endtask
  // A floating ID always gives the zero resistor code.
  task automatic set_id(input logic [4:0] code, input logic open);
    id_open = open;
    id_code = open ? 5'h00 : code;
  endtask
endmodule
`default_nettype wire

//--- test/test_accessory_detect_switch_ctrl.sv
// Bench of the detection core: register reads, attach, detach, soft reset.
// Assumes the accessory model in its own file and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_accessory_detect_switch_ctrl
  import accd_pkg::*;
;
  typedef struct {logic [7:0] addr; logic [7:0] exp;} accd_row_t;
  logic       clock, reset, reg_wr, reg_rd, irq_n_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic       hdp, hdm, aud, mic, fet, id_open, vbus_ok;
  logic       adc, ovp, bias;
  logic [4:0] id_code;
  int         err_total, comparisons;
  // Reset values, one unmapped offset last.
  accd_row_t  rows [7] = '{'{8'h02, 8'h45}, '{8'h03, 8'h00}, '{8'h04, 8'h00},
    '{8'h05, 8'h00}, '{8'h08, 8'h07}, '{8'h14, 8'h00}, '{8'h01, 8'h00}};
  // Switch outputs packed as one byte for comparison.
  wire  [7:0] sw = {3'h0, hdp, hdm, aud, mic, fet};
  // Measurement power, MIC guard and D+ bias packed as one byte.
  wire  [7:0] aux = {5'h0, adc, ovp, bias};

  // The clock toggles every half period.
  always #5 clock = ~clock;

  accd_accessory_model peer_u (.id_code(id_code), .id_open(id_open),
                               .vbus_ok(vbus_ok));
  accd_core dut_u (.clock(clock), .reset(reset),
    .connector_id_pin_code(id_code), .connector_id_pin_open(id_open),
    .vbus_cmp_pin(vbus_ok), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .irq_n_out(irq_n_out), .host_port1_dplus(hdp), .host_port1_dminus(hdm),
    .audio_sw_close(aud), .mic_sw_close(mic), .vbus_fet_close(fet),
    .id_adc_enable(adc), .mic_overvoltage_guard_enable(ovp),
    .dplus_bias_enable(bias));

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Compares one value with its expectation.
  task automatic check(input string nm, input logic [7:0] s, e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One-cycle write strobe, then one idle edge before the next request.
  task automatic wr(input logic [7:0] a, d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1 reg_wr = 1'b0;
    @(posedge clock);
    #1;
  endtask
  // One-cycle read strobe; data is registered at the taking edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge clock);
    #1;
  endtask
  // Waits a bounded time for the interrupt line to go low.
  task automatic wait_irq();
    for (int i = 0; i < 20; i++) begin
      if (irq_n_out === 1'b0) return;
      @(posedge clock);
      #1;
    end
    err_total++;
    $display("[FAIL] irq_n_out expected 0 seen 1");
    stop_test();
  endtask

  // Main sequence: table of reset values, then hand-written cases.
  initial begin
    clock = 0; reset = 1; reg_wr = 0; reg_rd = 0;
    reg_addr = 8'h00; reg_wdata = 8'h00; err_total = 0; comparisons = 0;
    repeat (12) @(posedge clock);
    #1 reset = 0;
    @(posedge clock);
    #1 check("irq idle", {7'h0, irq_n_out}, 8'h01);
    foreach (rows[i]) begin
      rd(rows[i].addr, v);
      check("reset value", v, rows[i].exp);
    end
    // Masked VBUS attach in the default manual mode.
    peer_u.set_vbus(1'b1);
    repeat (8) @(posedge clock);
    #1 check("attach switches", sw, 8'h19);
    check("masked irq", {7'h0, irq_n_out}, 8'h01);
    rd(OFS_FLAGS, v);
    check("vbus attach flags", v, 8'h09);
    wr(OFS_CTRL, 8'h44);
    rd(OFS_FLAGS, v);
    check("flags cleared", v, 8'h00);
    // Detach with the mask cleared pulls the line low and opens all.
    peer_u.set_vbus(1'b0);
    wait_irq();
    repeat (2) @(posedge clock);
    #1 check("detach switches", sw, 8'h00);
    rd(OFS_FLAGS, v);
    check("detach flags", v, 8'h0a);
    repeat (2) @(posedge clock);
    #1 check("irq released", {7'h0, irq_n_out}, 8'h01);
    // Soft reset clears the event mask but spares chip_control.
    wr(OFS_EVMASK, 8'h0f);
    wr(OFS_CTRL, 8'h04);
    repeat (3) @(posedge clock);
    #1 rd(OFS_EVMASK, v);
    check("mask after soft reset", v, 8'h00);
    rd(OFS_CTRL, v);
    check("ctrl kept", v, 8'h44);
    // Manual FET field open keeps the FET open on a valid VBUS.
    wr(OFS_MANSW, 8'h04);
    peer_u.set_vbus(1'b1);
    wait_irq();
    repeat (2) @(posedge clock);
    #1 check("manual fet open", sw, 8'h18);
    // Key resistor: three agreeing samples at two thousand cycles each.
    peer_u.set_id(CODE_SEND_END, 1'b0);
    repeat (6200) @(posedge clock);
    #1 rd(OFS_RCODE, v);
    check("resistor code", v, 8'h0f);
    check("aux outputs on id", aux, 8'h04);
    rd(OFS_FLAGS, v);
    check("resistance flag", v & 8'h04, 8'h04);
    // Float while monitoring: two samples give the zero code.
    peer_u.set_id(5'h00, 1'b1);
    repeat (4200) @(posedge clock);
    #1 rd(OFS_RCODE, v);
    check("float code", v, 8'h00);
    rd(OFS_STATUS, v);
    check("open status", v & 8'h02, 8'h00);
    // Automatic mode with every manual state open: a plain port closes
    // the host path once discovery is done.
    wr(OFS_MANCHG, 8'h04);
    wr(OFS_MANSW, 8'h00);
    wr(OFS_CTRL, 8'h60);
    repeat (2) @(posedge clock);
    #1 check("auto switches", sw, 8'h19);
    check("aux outputs open id", aux, 8'h03);
    // A key code is not an auto-switch code, so the host path opens.
    peer_u.set_id(CODE_SEND_END, 1'b0);
    repeat (4200) @(posedge clock);
    #1 check("auto key switches", sw, 8'h01);
    stop_test();
  end
endmodule
`default_nettype wire
